// ==== xltf_map.svh ====
// register map, field positions and timing for the x-y trigger filter
// assumes one 125 mhz clock and an axi4-lite register slave
// Functional notes
// RULE_01: Each filter is off or qualifies over 3, 4, 6, 10, 18, 34, 66 or 130 samples.
// RULE_02: With a filter on, a condition that reverses inside the window fires nothing.
// RULE_03: Trigger conditions are sampled once per 125 us tick, whatever the drawing mode.
// RULE_04: Each pattern position is 1, 0 or don't care, and only cared positions must agree.
// RULE_05: Pattern triggering exists only on channels 2 and 3.
// RULE_06: In and mode every specified pattern group must match at once.
// RULE_07: In or mode one matching specified pattern group is enough.
// RULE_08: The polarity bit fires on the combined match when true, on its absence when false.
// RULE_09: The logic path uses the same filter choices and behaviour as the analog path.
// RULE_10: A channel whose source is off cannot become the level readout source.
// RULE_11: Any one enabled source fires the overall trigger.
// RULE_12: With every source off, the start command itself fires the trigger.
// RULE_13: The hold counter restarts on a change and fires on the tick it reaches the count.
`ifndef XLTF_MAP_SVH
`define XLTF_MAP_SVH
`define XLTF_AW 8
`define XLTF_OFS_CTRL 8'h00
`define XLTF_OFS_READOUT 8'h04
`define XLTF_OFS_FILT 8'h08
`define XLTF_OFS_PAT2 8'h0c
`define XLTF_OFS_PAT3 8'h10
`define XLTF_OFS_STATUS 8'h14
`define XLTF_OFS_MASK 8'h18
`define XLTF_OFS_STATE 8'h1c
`define XLTF_CTRL_SRC 0
`define XLTF_CTRL_EXT 3
`define XLTF_CTRL_MAN 4
`define XLTF_CTRL_LOG 5
`define XLTF_FILT_W 4
`define XLTF_PAT_CARE 0
`define XLTF_PAT_VAL 8
`define XLTF_PAT_OR 16
`define XLTF_PAT_FALSE 17
`define XLTF_ST_TRIG 0
`define XLTF_ST_START 1
`define XLTF_RESP_OK 2'b00
`define XLTF_RESP_ERR 2'b10
`define XLTF_TICK_US 125
`define XLTF_CLK_MHZ 125
`define XLTF_LEN_1 8'h03
`define XLTF_LEN_2 8'h04
`define XLTF_LEN_3 8'h06
`define XLTF_LEN_4 8'h0a
`define XLTF_LEN_5 8'h12
`define XLTF_LEN_6 8'h22
`define XLTF_LEN_7 8'h42
`define XLTF_LEN_8 8'h82
`endif

// ==== xltf_pkg.sv ====
// types of the x-y trigger filter
// assumes xltf_map.svh is on the include path
package xltf_pkg;
`include "xltf_map.svh"
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [`XLTF_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [2:0] src_en;
    logic ext_en;
    logic man_en;
    logic [1:0] log_unit;
    logic [1:0] readout;
    logic [2:0][`XLTF_FILT_W-1:0] filt;
    logic [1:0][17:0] pat;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic trig;
    logic [31:0] tick_cnt;
    logic [2:0] prev;
    logic [2:0][7:0] hold;
  } xltf_state_t;
endpackage

// ==== xltf_top.sv ====
// x-y trigger qualification: pattern match, hold filter, source combine
// assumes synchronous probe levels and single-cycle ext/manual/start pulses
`timescale 1ns/10ps
module xltf_top
  import xltf_pkg::*;
#(
  parameter int TICK_CYCLES = `XLTF_TICK_US * `XLTF_CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [`XLTF_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`XLTF_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger inputs
  input wire logic [2:0] ana_cond,
  input wire logic [7:0] logic_in_ch2,
  input wire logic [7:0] logic_in_ch3,
  input wire logic ext_trig,
  input wire logic man_press,
  input wire logic start_cmd,
  // outputs
  output logic trig_out,
  output logic irq
);

  xltf_state_t state_reg;
  xltf_state_t state_next;
  logic [1:0][7:0] lin;
  logic [1:0] lcond;
  logic [1:0] raw;
  logic [2:0] cond;
  logic [2:0] fire_ch;
  logic tick;
  logic start_fire;
  logic fire;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // [RULE_01] off (0 or unused codes) or one of eight lengths
  function automatic logic [7:0] filt_len(input logic [`XLTF_FILT_W-1:0] sel);
    case (sel)
      4'h1: return `XLTF_LEN_1;
      4'h2: return `XLTF_LEN_2;
      4'h3: return `XLTF_LEN_3;
      4'h4: return `XLTF_LEN_4;
      4'h5: return `XLTF_LEN_5;
      4'h6: return `XLTF_LEN_6;
      4'h7: return `XLTF_LEN_7;
      4'h8: return `XLTF_LEN_8;
      default: return 8'h00;
    endcase
  endfunction

  assign lin[0] = logic_in_ch2;
  assign lin[1] = logic_in_ch3;

  // pattern units exist only for channels 2 and 3 [RULE_05]
  for (genvar l = 0; l < 2; l++) begin : g_pat
    logic [7:0] care;
    logic [7:0] val;
    logic [7:0] miss;
    logic spec_a;
    logic spec_b;
    logic hit_a;
    logic hit_b;
    assign care = state_reg.pat[l][`XLTF_PAT_CARE +: 8];
    assign val = state_reg.pat[l][`XLTF_PAT_VAL +: 8];
    assign miss = (lin[l] ^ val) & care; // [RULE_04]
    assign spec_a = |care[3:0];
    assign spec_b = |care[7:4];
    assign hit_a = ~|miss[3:0];
    assign hit_b = ~|miss[7:4];
    // a group with no cared position is not specified and takes no part
    assign raw[l] = state_reg.pat[l][`XLTF_PAT_OR] ?
      ((spec_a & hit_a) | (spec_b & hit_b)) : // [RULE_07]
      ((spec_a | spec_b) & (~spec_a | hit_a) & (~spec_b | hit_b)); // [RULE_06]
    assign lcond[l] = raw[l] ^ state_reg.pat[l][`XLTF_PAT_FALSE]; // [RULE_08]
  end

  // channel 1 is always analog; 2 and 3 follow the fitted unit
  assign cond[0] = ana_cond[0];
  assign cond[1] = state_reg.log_unit[0] ? lcond[0] : ana_cond[1];
  assign cond[2] = state_reg.log_unit[1] ? lcond[1] : ana_cond[2];

  assign tick = (state_reg.tick_cnt == 32'(TICK_CYCLES - 1)); // [RULE_03]
  assign start_fire = ~(|state_reg.src_en | state_reg.ext_en | state_reg.man_en) & start_cmd; // [RULE_12]
  assign fire = |(fire_ch & state_reg.src_en) | (state_reg.ext_en & ext_trig)
              | (state_reg.man_en & man_press) | start_fire; // [RULE_11]

  always_comb begin
    logic [31:0] m;
    logic [31:0] rd;
    logic [1:0] rclr;
    logic [7:0] len;
    m = 32'h0;
    rd = 32'h0;
    rclr = 2'b00;
    len = 8'h00;
    state_next = state_reg;
    fire_ch = 3'b000;

    state_next.tick_cnt = tick ? 32'h0 : state_reg.tick_cnt + 32'h1;

    // same filter for analog and logic sources [RULE_09]
    for (int c = 0; c < 3; c++) begin
      len = filt_len(state_reg.filt[c]);
      if (tick) begin
        state_next.prev[c] = cond[c];
        if (cond[c] != state_reg.prev[c]) begin
          state_next.hold[c] = 8'h01; // [RULE_13]
        end else if (state_reg.hold[c] != 8'hff) begin
          state_next.hold[c] = state_reg.hold[c] + 8'h01;
        end
        if (len == 8'h00) begin
          fire_ch[c] = cond[c] & ~state_reg.prev[c];
        end else begin
          // a reversal restarts the count, so short pulses never fire [RULE_02]
          fire_ch[c] = cond[c] & (state_next.hold[c] == len); // [RULE_13]
        end
      end
    end
    state_next.trig = fire;

    // write: address and data in either order, response after both
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `XLTF_RESP_OK;
      case (state_reg.waddr)
        `XLTF_OFS_CTRL: begin
          m = merge({25'h0, state_reg.log_unit, state_reg.man_en, state_reg.ext_en,
                     state_reg.src_en}, state_reg.wdata, state_reg.wstrb);
          state_next.src_en = m[`XLTF_CTRL_SRC +: 3];
          state_next.ext_en = m[`XLTF_CTRL_EXT];
          state_next.man_en = m[`XLTF_CTRL_MAN];
          state_next.log_unit = m[`XLTF_CTRL_LOG +: 2];
        end
        `XLTF_OFS_READOUT: begin
          m = merge({30'h0, state_reg.readout}, state_reg.wdata, state_reg.wstrb);
          // an off or absent channel is refused, old choice kept [RULE_10]
          if (m[1:0] != 2'h3 && state_reg.src_en[m[1:0]]) begin
            state_next.readout = m[1:0];
          end
        end
        `XLTF_OFS_FILT: begin
          m = merge({20'h0, state_reg.filt}, state_reg.wdata, state_reg.wstrb);
          state_next.filt = m[11:0];
        end
        `XLTF_OFS_PAT2: begin
          m = merge({14'h0, state_reg.pat[0]}, state_reg.wdata, state_reg.wstrb);
          state_next.pat[0] = m[17:0];
        end
        `XLTF_OFS_PAT3: begin
          m = merge({14'h0, state_reg.pat[1]}, state_reg.wdata, state_reg.wstrb);
          state_next.pat[1] = m[17:0];
        end
        `XLTF_OFS_MASK: begin
          m = merge({30'h0, state_reg.mask}, state_reg.wdata, state_reg.wstrb);
          state_next.mask = m[1:0];
        end
        `XLTF_OFS_STATUS, `XLTF_OFS_STATE: begin
        end
        default: state_next.bresp = `XLTF_RESP_ERR;
      endcase
    end
    state_next.awready = ~state_next.aw_got;
    state_next.wready = ~state_next.w_got;

    // read: one per handshake, status cleared by its read
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = `XLTF_RESP_OK;
      case (s_axi_araddr)
        `XLTF_OFS_CTRL: rd = {25'h0, state_reg.log_unit, state_reg.man_en, state_reg.ext_en,
                              state_reg.src_en};
        `XLTF_OFS_READOUT: rd = {30'h0, state_reg.readout};
        `XLTF_OFS_FILT: rd = {20'h0, state_reg.filt};
        `XLTF_OFS_PAT2: rd = {14'h0, state_reg.pat[0]};
        `XLTF_OFS_PAT3: rd = {14'h0, state_reg.pat[1]};
        `XLTF_OFS_STATUS: begin
          rd = {30'h0, state_reg.status};
          rclr = state_reg.status;
        end
        `XLTF_OFS_MASK: rd = {30'h0, state_reg.mask};
        `XLTF_OFS_STATE: rd = {26'h0, state_reg.prev, cond};
        default: state_next.rresp = `XLTF_RESP_ERR;
      endcase
      state_next.rdata = rd;
    end

    // clear only bits seen by the read; a new event still wins
    state_next.status = state_reg.status & ~rclr;
    state_next.status[`XLTF_ST_TRIG] = state_next.status[`XLTF_ST_TRIG] | fire;
    state_next.status[`XLTF_ST_START] = state_next.status[`XLTF_ST_START] | start_fire;
    state_next.irq = |(state_next.status & state_next.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign trig_out = state_reg.trig;
  assign irq = state_reg.irq;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tick_spacing: assert property (tick && TICK_CYCLES > 1 |=> !tick) // [RULE_03]
    else $error("sample tick came twice in a row");
  a_chan_tick_only: assert property (|fire_ch |-> tick) // [RULE_03]
    else $error("channel fired off the sample tick");
  // unused codes 9..15 mean off, so they take the edge path and are left out of the hold check
  a_filt_hold: assert property (fire_ch[0] && filt_len(state_reg.filt[0]) != 8'h00 // [RULE_02]
    |=> state_reg.hold[0] == filt_len($past(state_reg.filt[0])))
    else $error("filtered fire before full hold");
  a_filt_restart: assert property (tick && cond[1] != state_reg.prev[1] // [RULE_13]
    |=> state_reg.hold[1] == 8'h01)
    else $error("hold count not restarted on change");
  a_start_fall: assert property (start_fire |=> trig_out ##1 irq || !state_reg.mask[1]) // [RULE_12]
    else $error("start command did not trigger");
  a_src_any: assert property (state_reg.ext_en && ext_trig |=> trig_out) // [RULE_11]
    else $error("enabled source did not trigger");
  // and mode: some position cared for, and every cared position agrees with the probe
  a_and_mode: assert property (!state_reg.pat[0][`XLTF_PAT_OR] // [RULE_06]
    |-> raw[0] == ((|state_reg.pat[0][`XLTF_PAT_CARE +: 8])
    && (((logic_in_ch2 ^ state_reg.pat[0][`XLTF_PAT_VAL +: 8])
    & state_reg.pat[0][`XLTF_PAT_CARE +: 8]) == 8'h00)))
    else $error("and match differs from pattern");
  a_polarity: assert property (lcond[1] == (raw[1] ^ state_reg.pat[1][`XLTF_PAT_FALSE])) // [RULE_08]
    else $error("polarity not applied");
  a_readout_src: assert property (state_next.readout != state_reg.readout // [RULE_10]
    |-> state_reg.src_en[state_next.readout])
    else $error("readout moved to a switched off channel");
endmodule

// ==== xltf_probe_model.sv ====
// model of the probe and comparator units that feed the trigger filter
// assumes the bench sets wanted levels just after a rising edge of aclk
`timescale 1ns/10ps
module xltf_probe_model (
  // clock
  input wire logic aclk,
  // wanted levels
  input wire logic [2:0] ana_set,
  input wire logic [7:0] ch2_set,
  input wire logic [7:0] ch3_set,
  // thresholded levels towards the filter
  output logic [2:0] ana_cond,
  output logic [7:0] logic_in_ch2,
  output logic [7:0] logic_in_ch3
);
  // one register stage, so a level changes only on the design's sampling edge
  always_ff @(posedge aclk) begin
    ana_cond <= ana_set;
    logic_in_ch2 <= ch2_set;
    logic_in_ch3 <= ch3_set;
  end
endmodule

// ==== tb_xy_logic_trigger_filter.sv ====
// self-checking bench for the x-y trigger filter over axi4-lite
// assumes xltf_pkg compiled first and xltf_map.svh on the include path
`timescale 1ns/10ps
`include "xltf_map.svh"
module tb_xy_logic_trigger_filter;
  logic aclk, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trig_out, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [2:0] ana_cond, ana_set = 3'h0;
  logic [7:0] logic_in_ch2, logic_in_ch3, ch2_set = 8'h00, ch3_set = 8'h00;
  logic ext_trig = 1'b0, man_press = 1'b0, start_cmd = 1'b0;
  int num_errors = 0, compares = 0, fires;
  int lens [8] = '{3, 4, 6, 10, 18, 34, 66, 130};

  xltf_top #(.TICK_CYCLES(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ana_cond, .logic_in_ch2, .logic_in_ch3, .ext_trig, .man_press, .start_cmd, .trig_out, .irq);
  xltf_probe_model i_probe (.aclk, .ana_set, .ch2_set, .ch3_set, .ana_cond, .logic_in_ch2, .logic_in_ch3);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tmo();
    num_errors++;
    $display("[FAIL] handshake expected answer seen timeout");
    final_report();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // holds both channels up until each is taken; bready up until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw;
    bit w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 64) tmo();
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 64) tmo();
  endtask

  // counts trig_out high cycles, sampled as the design's edge sees them
  task automatic run(input int c);
    fires = 0;
    repeat (c) begin
      @(posedge aclk);
      if (trig_out === 1'b1) fires++;
    end
  endtask

  // k: 0 start, 1 external, 2 manual; one cycle wide
  task automatic pulse(input int k);
    @(posedge aclk);
    {man_press, ext_trig, start_cmd} <= 3'(1 << k);
    @(posedge aclk);
    {man_press, ext_trig, start_cmd} <= 3'b000;
    run(6);
  endtask

  // pattern p on one channel, other channel no groups; fire on change v to w
  task automatic pat_case(input bit c3, input logic [17:0] p, input logic [7:0] v, input logic [7:0] w);
    wr(c3 ? `XLTF_OFS_PAT3 : `XLTF_OFS_PAT2, {14'h0, p});
    wr(c3 ? `XLTF_OFS_PAT2 : `XLTF_OFS_PAT3, 32'h0);
    {ch3_set, ch2_set} <= c3 ? {v, 8'h00} : {8'h00, v};
    run(40);
    {ch3_set, ch2_set} <= c3 ? {w, 8'h00} : {8'h00, w};
    run(40);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`XLTF_OFS_CTRL);
    chk("ctrl reset", 32'h0, rdat);
    rd(`XLTF_OFS_FILT);
    chk("filt reset", 32'h0, rdat);
    rd(8'h20);
    chk("unmapped rresp", 32'(`XLTF_RESP_ERR), 32'(resp));
    wr(8'h24, 32'h1);
    chk("unmapped bresp", 32'(`XLTF_RESP_ERR), 32'(resp));
    $display("test registers done");
    pulse(0);
    chk("start fires", 32'd1, fires);
    chk("irq masked", 32'd0, 32'(irq));
    rd(`XLTF_OFS_STATUS);
    chk("status start", 32'h3, rdat);
    wr(`XLTF_OFS_MASK, 32'h1);
    wr(`XLTF_OFS_CTRL, 32'h1);
    pulse(0);
    chk("start ignored", 32'd0, fires);
    ana_set <= 3'b001;
    run(12);
    chk("tick fire", 32'd1, fires);
    run(28);
    chk("once per rise", 32'd0, fires);
    chk("irq set", 32'd1, 32'(irq));
    rd(`XLTF_OFS_STATUS);
    chk("status trig", 32'h1, rdat);
    chk("irq cleared", 32'd0, 32'(irq));
    wr(`XLTF_OFS_CTRL, 32'h9);
    pulse(1);
    chk("ext fires", 32'd1, fires);
    pulse(2);
    chk("manual off", 32'd0, fires);
    wr(`XLTF_OFS_CTRL, 32'h11);
    pulse(2);
    chk("manual on", 32'd1, fires);
    ana_set <= 3'b000;
    $display("test sources done");
    wr(`XLTF_OFS_READOUT, 32'h2);
    rd(`XLTF_OFS_READOUT);
    chk("readout off ch", 32'h0, rdat);
    wr(`XLTF_OFS_CTRL, 32'h3);
    wr(`XLTF_OFS_READOUT, 32'h1);
    rd(`XLTF_OFS_READOUT);
    chk("readout on ch", 32'h1, rdat);
    $display("test readout done");
    for (int i = 0; i < 8; i++) begin
      wr(`XLTF_OFS_FILT, 32'(i + 1));
      ana_set <= 3'b001;
      run((lens[i] - 1) * 8 - 4);
      chk("early", 32'd0, fires);
      ana_set <= 3'b000;
      run(24);
      chk("reversed", 32'd0, fires);
      ana_set <= 3'b001;
      run(lens[i] * 8 + 16);
      chk("held", 32'd1, fires);
      rd(`XLTF_OFS_STATE);
      chk("state held", 32'h9, rdat);
      ana_set <= 3'b000;
      run(16);
    end
    $display("test filter done");
    wr(`XLTF_OFS_FILT, 32'h0);
    wr(`XLTF_OFS_CTRL, 32'h66);
    pat_case(1, 18'h0a5ff, 8'h00, 8'ha5);
    chk("and all", 32'd1, fires);
    pat_case(1, 18'h0a5ff, 8'h00, 8'h05);
    chk("and part", 32'd0, fires);
    pat_case(1, 18'h1a5ff, 8'h00, 8'h05);
    chk("or part", 32'd1, fires);
    pat_case(1, 18'h0090b, 8'h00, 8'h0d);
    chk("dont care", 32'd1, fires);
    pat_case(1, 18'h2a5ff, 8'ha5, 8'h00);
    chk("false match", 32'd1, fires);
    pat_case(0, 18'h0a5ff, 8'h00, 8'ha5);
    chk("ch2 pattern", 32'd1, fires);
    wr(`XLTF_OFS_FILT, 32'h100);
    pat_case(1, 18'h0a5ff, 8'h00, 8'ha5);
    chk("logic filter", 32'd1, fires);
    $display("test pattern done");
    final_report();
  end
endmodule
